// ==== core/umls_cfg.svh ====
// Constants for the modem control, line status and modem status block.
// Assumes inclusion by bare name from every file of the block but the interface.
`ifndef UMLS_CFG_SVH
`define UMLS_CFG_SVH

// Register addresses on the three-bit processor address
`define UMLS_ADDR_HOLD  3'h0
`define UMLS_ADDR_MCTL  3'h4
`define UMLS_ADDR_LSTAT 3'h5
`define UMLS_ADDR_MSTAT 3'h6

// Modem control field positions and reset
`define UMLS_MC_TERM    0
`define UMLS_MC_SEND    1
`define UMLS_MC_USRA    2
`define UMLS_MC_USRB    3
`define UMLS_MC_LOOP    4
`define UMLS_MC_W       5
`define UMLS_MC_RST     5'h00

// Line format and interrupt enable fields that this block reads
`define UMLS_LF_PEN     3
`define UMLS_LF_EPS     4
`define UMLS_LF_DLAB    7
`define UMLS_IE_MODEM   3

// Reset values
`define UMLS_PIN_RST    4'hF
`define UMLS_RD_RST     8'h00
`define UMLS_ZERO3      3'h0

`endif

// ==== core/umls_if.sv ====
// Internal carrier between the top and its two status modules.
// Assumes all three sit on core_clk.
`timescale 1ns/10ps
`default_nettype none

interface umls_if;
    logic       ce;
    logic       lsr_rd;
    logic       hold_rd;
    logic       msr_rd;
    logic [3:0] levels;
    logic [7:0] msr_val;
    logic       fifo_active;
    logic       head_valid;
    logic [7:0] head_data;
    logic       head_pe;
    logic       head_fe;
    logic       head_bi;
    logic       err_any;
    logic       char_done;
    logic       full;
    logic [7:0] line_format;
    logic       ovr;
    logic       pe;
    logic       fe;
    logic       bi;
    logic       ferr;
    logic       push;
    logic       pop;

    modport top (output ce, lsr_rd, hold_rd, msr_rd, levels, fifo_active, head_valid,
                 head_data, head_pe, head_fe, head_bi, err_any, char_done, full,
                 line_format,
                 input msr_val, ovr, pe, fe, bi, ferr, push, pop);
    modport mst (input ce, msr_rd, levels, output msr_val);
    modport rxf (input ce, lsr_rd, hold_rd, fifo_active, head_valid, head_data, head_pe,
                 head_fe, head_bi, err_any, char_done, full, line_format,
                 output ovr, pe, fe, bi, ferr, push, pop);
endinterface : umls_if

`default_nettype wire

// ==== core/umls_modem_status.sv ====
// Modem status tracking: delayed levels and sticky change flags.
// Assumes modem levels are synchronous and already muxed for loop-back.
`timescale 1ns/10ps
`default_nettype none
`include "umls_cfg.svh"

module umls_modem_status
(
    input  wire logic core_clk,
    input  wire logic arst_n,
    umls_if.mst       bus
);
    import umls_pkg::*;

    umls_msr_st_t st;
    umls_msr_st_t next_st;
    logic [3:0]   change;

    // Levels order {carrier, call, ready, clear}; change seen two cycles late
    always_comb
    begin
        next_st        = st;
        change         = st.stage2 ^ st.prev;
        change[2]      = st.stage2[2] & ~st.prev[2];
        next_st.stage1 = bus.levels;
        next_st.stage2 = st.stage1;
        next_st.prev   = st.stage2;
        // A change in the read cycle survives the clear
        next_st.delta  = change | (st.delta & ~{4{bus.msr_rd}});
        if (!bus.ce)
        begin
            next_st = st;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '{stage1: `UMLS_PIN_RST, stage2: `UMLS_PIN_RST,
                    prev: `UMLS_PIN_RST, delta: 4'h0};
        end
        else
        begin
            st <= next_st;
        end
    end

    // Upper nibble is the inverted pin level
    assign bus.msr_val = {~st.stage2, st.delta};

endmodule : umls_modem_status

`default_nettype wire

// ==== core/umls_pkg.sv ====
// Types shared by the modem and line status block.
// Assumes umls_cfg.svh supplies the widths.
`include "umls_cfg.svh"

package umls_pkg;

    // Top-level state
    typedef struct packed {
        logic [`UMLS_MC_W-1:0] mctl;
        logic [7:0]            rd_data;
        logic                  term_low;
        logic                  send_low;
        logic                  usra_low;
        logic                  usrb_low;
        logic                  ser_out;
        logic                  ser_rx;
        logic                  irq;
        logic                  irq_low;
        logic                  modem_int;
        logic                  hold_empty;
        logic                  xmit_empty;
        logic                  thr_wr;
    } umls_top_st_t;

    // Modem input tracking: two delay stages and the previous level
    typedef struct packed {
        logic [3:0] stage1;
        logic [3:0] stage2;
        logic [3:0] prev;
        logic [3:0] delta;
    } umls_msr_st_t;

    // Receive error flags, push/pop strobes and head reload tracking
    typedef struct packed {
        logic ovr;
        logic pe;
        logic fe;
        logic bi;
        logic ferr;
        logic push;
        logic pop;
        logic reload;
        logic prev_valid;
    } umls_rxf_st_t;

endpackage : umls_pkg

// ==== core/umls_rx_flags.sv ====
// Receive error flags for the head character, overrun and push/pop.
// Assumes an external receive FIFO that pops on the cycle pop is high.
`timescale 1ns/10ps
`default_nettype none
`include "umls_cfg.svh"

module umls_rx_flags
#(
    parameter bit DERIVED_BREAK_OPTION = 1'b0
)
(
    input  wire logic core_clk,
    input  wire logic arst_n,
    umls_if.rxf       bus
);
    import umls_pkg::*;

    umls_rxf_st_t st;
    umls_rxf_st_t next_st;
    logic [7:0]   wmask;
    logic         brk_calc;
    logic         load;
    logic         clr;

    always_comb
    begin
        next_st = st;
        clr     = bus.lsr_rd;
        // Break rebuilt from head data: all data zero, frame bad, parity as zero would give
        unique case (bus.line_format[1:0])
            2'h0:    wmask = 8'h1F;
            2'h1:    wmask = 8'h3F;
            2'h2:    wmask = 8'h7F;
            default: wmask = 8'hFF;
        endcase
        brk_calc = bus.head_fe & ((bus.head_data & wmask) == 8'h00)
                   & (~bus.line_format[`UMLS_LF_PEN]
                      | (bus.head_pe == ~bus.line_format[`UMLS_LF_EPS]));
        // Reload when a new head appears: after a pop, or from empty
        load = bus.head_valid & (st.reload | ~st.prev_valid);
        next_st.prev_valid = bus.head_valid;
        next_st.pop        = bus.hold_rd & bus.head_valid;
        next_st.reload     = st.pop;
        if (load)
        begin
            next_st.pe = bus.head_pe;
            next_st.fe = bus.head_fe;
            next_st.bi = DERIVED_BREAK_OPTION ? brk_calc : bus.head_bi;
        end
        else
        begin
            next_st.pe = st.pe & ~clr;
            next_st.fe = st.fe & ~clr;
            next_st.bi = st.bi & ~clr;
        end
        // Overrun set wins over the read clear; never queued
        next_st.ovr  = (bus.char_done & bus.full) | (st.ovr & ~clr);
        // Non-FIFO overwrites the holding register, FIFO discards the new one
        next_st.push = bus.char_done & (~bus.full | ~bus.fifo_active);
        next_st.ferr = bus.fifo_active & (bus.err_any | (st.ferr & ~clr));
        if (!bus.ce)
        begin
            next_st = st;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign bus.ovr  = st.ovr;
    assign bus.pe   = st.pe;
    assign bus.fe   = st.fe;
    assign bus.bi   = st.bi;
    assign bus.ferr = st.ferr;
    assign bus.push = st.push;
    assign bus.pop  = st.pop;

endmodule : umls_rx_flags

`default_nettype wire

// ==== core/umls_top.sv ====
// Modem control, line status and modem status of a serial transceiver.
// Assumes synchronous pins, one clock, and outside FIFOs and serialisers.
`timescale 1ns/10ps
`default_nettype none
`include "umls_cfg.svh"

module umls_top
#(
    parameter bit GLOBAL_MASK_OPTION   = 1'b1,
    parameter bit DERIVED_BREAK_OPTION = 1'b0
)
(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    input  wire logic [2:0] addr,
    input  wire logic       cs1,
    input  wire logic       cs2,
    input  wire logic       cs_low,
    input  wire logic       rd_strobe,
    input  wire logic       wr_strobe,
    input  wire logic [7:0] wr_data,
    output var  logic [7:0] rd_data,
    input  wire logic [7:0] line_format,
    input  wire logic [7:0] interrupt_enable,
    input  wire logic       int_pending,
    output var  logic       irq,
    output var  logic       irq_low,
    output var  logic       modem_int,
    input  wire logic       send_clear_low,
    input  wire logic       set_ready_low,
    input  wire logic       call_indicator_low,
    input  wire logic       carrier_detect_low,
    output var  logic       terminal_ready_low,
    output var  logic       send_request_low,
    output var  logic       user_pin_a_low,
    output var  logic       user_pin_b_low,
    input  wire logic       serial_in,
    output var  logic       serial_out,
    input  wire logic       tx_serial,
    output var  logic       rx_serial,
    input  wire logic       fifo_active,
    input  wire logic       rx_head_valid,
    input  wire logic [7:0] rx_head_data,
    input  wire logic       rx_head_parity_err,
    input  wire logic       rx_head_frame_err,
    input  wire logic       rx_head_break,
    input  wire logic       rx_fifo_err_any,
    input  wire logic       rx_char_done,
    input  wire logic       rx_storage_full,
    output var  logic       rx_push,
    output var  logic       rx_pop,
    input  wire logic       tx_holding_empty,
    input  wire logic       tx_shift_empty,
    output var  logic       tx_holding_write
);
    import umls_pkg::*;

    umls_if       sbus ();
    umls_top_st_t st;
    umls_top_st_t next_st;
    logic         wr_hit;
    logic         thr_pulse;
    logic         sel;
    logic         rd_hit;
    logic         dlab;
    logic         loop;
    logic [3:0]   mod_levels;
    logic [7:0]   lstat;
    logic [7:0]   read_mux;
    logic         gate;

    // Chip selects must all agree before either strobe counts
    assign sel     = cs1 & cs2 & ~cs_low & clk_en;
    assign rd_hit  = sel & rd_strobe;
    assign wr_hit  = sel & wr_strobe;
    assign dlab    = line_format[`UMLS_LF_DLAB];
    assign loop    = st.mctl[`UMLS_MC_LOOP];

    // Holding write seen here clears the empty flags before the FIFO reacts
    assign thr_pulse = wr_hit & (addr == `UMLS_ADDR_HOLD) & ~dlab;

    // Modem input levels, replaced by the control outputs in loop-back
    always_comb
    begin
        if (loop)
        begin
            mod_levels = ~{st.mctl[`UMLS_MC_USRB], st.mctl[`UMLS_MC_USRA],
                           st.mctl[`UMLS_MC_TERM], st.mctl[`UMLS_MC_SEND]};
        end
        else
        begin
            mod_levels = {carrier_detect_low, call_indicator_low,
                          set_ready_low, send_clear_low};
        end
    end

    // Signals carried to the two status modules
    assign sbus.ce          = clk_en;
    assign sbus.lsr_rd      = rd_hit & (addr == `UMLS_ADDR_LSTAT);
    assign sbus.msr_rd      = rd_hit & (addr == `UMLS_ADDR_MSTAT);
    assign sbus.hold_rd     = rd_hit & (addr == `UMLS_ADDR_HOLD) & ~dlab;
    assign sbus.levels      = mod_levels;
    assign sbus.fifo_active = fifo_active;
    assign sbus.head_valid  = rx_head_valid;
    assign sbus.head_data   = rx_head_data;
    assign sbus.head_pe     = rx_head_parity_err;
    assign sbus.head_fe     = rx_head_frame_err;
    assign sbus.head_bi     = rx_head_break;
    assign sbus.err_any     = rx_fifo_err_any;
    assign sbus.char_done   = rx_char_done;
    assign sbus.full        = rx_storage_full;
    assign sbus.line_format = line_format;

    umls_modem_status u_msr
    (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .bus      (sbus.mst)
    );

    umls_rx_flags
    #(
        .DERIVED_BREAK_OPTION (DERIVED_BREAK_OPTION)
    )
    u_rxf
    (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .bus      (sbus.rxf)
    );

    // Line status as software sees it; data ready follows the queue live
    always_comb
    begin
        lstat    = 8'h00;
        lstat[0] = rx_head_valid;
        lstat[1] = sbus.ovr;
        lstat[2] = sbus.pe;
        lstat[3] = sbus.fe;
        lstat[4] = sbus.bi;
        lstat[5] = st.hold_empty;
        lstat[6] = st.xmit_empty;
        lstat[7] = sbus.ferr;
    end

    // Read mux; addresses owned by other blocks answer zero here
    always_comb
    begin
        unique case (addr)
            `UMLS_ADDR_MCTL:
            begin
                read_mux = {`UMLS_ZERO3, st.mctl};
            end
            `UMLS_ADDR_LSTAT:
            begin
                read_mux = lstat;
            end
            `UMLS_ADDR_MSTAT:
            begin
                read_mux = sbus.msr_val;
            end
            default:
            begin
                read_mux = `UMLS_RD_RST;
            end
        endcase
    end

    // Global mask gate; applies in loop-back as well
    assign gate = ~GLOBAL_MASK_OPTION | st.mctl[`UMLS_MC_USRB];

    // Next state for registers, pins and status
    always_comb
    begin
        next_st = st;
        // Only five bits are stored so the upper three cannot stick
        if (wr_hit && addr == `UMLS_ADDR_MCTL)
        begin
            next_st.mctl = wr_data[`UMLS_MC_W-1:0];
        end
        if (rd_hit)
        begin
            next_st.rd_data = read_mux;
        end
        // Active-low pins, all forced inactive in loop-back
        next_st.term_low = loop | ~st.mctl[`UMLS_MC_TERM];
        next_st.send_low = loop | ~st.mctl[`UMLS_MC_SEND];
        next_st.usra_low = loop | ~st.mctl[`UMLS_MC_USRA];
        next_st.usrb_low = loop | ~st.mctl[`UMLS_MC_USRB];
        // Serial line held at mark while the stream loops inside
        next_st.ser_out  = loop | tx_serial;
        next_st.ser_rx   = loop ? tx_serial : serial_in;
        next_st.irq      = int_pending & gate;
        next_st.irq_low  = ~(int_pending & gate);
        next_st.modem_int = (|sbus.msr_val[3:0])
                            & interrupt_enable[`UMLS_IE_MODEM];
        // A write in flight masks the empty inputs until they catch up
        next_st.hold_empty = tx_holding_empty & ~thr_pulse & ~st.thr_wr;
        next_st.xmit_empty = tx_holding_empty & tx_shift_empty
                             & ~thr_pulse & ~st.thr_wr;
        next_st.thr_wr     = thr_pulse;
        if (!clk_en)
        begin
            next_st = st;
        end
    end

    // State register; everything freezes while the clock enable is low
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '{mctl: `UMLS_MC_RST, rd_data: `UMLS_RD_RST,
                    term_low: 1'b1, send_low: 1'b1, usra_low: 1'b1,
                    usrb_low: 1'b1, ser_out: 1'b1, ser_rx: 1'b1,
                    irq: 1'b0, irq_low: 1'b1, modem_int: 1'b0,
                    hold_empty: 1'b1, xmit_empty: 1'b1, thr_wr: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs come straight from flip-flops
    assign rd_data            = st.rd_data;
    assign irq                = st.irq;
    assign irq_low            = st.irq_low;
    assign modem_int          = st.modem_int;
    assign terminal_ready_low = st.term_low;
    assign send_request_low   = st.send_low;
    assign user_pin_a_low     = st.usra_low;
    assign user_pin_b_low     = st.usrb_low;
    assign serial_out         = st.ser_out;
    assign rx_serial          = st.ser_rx;
    assign rx_push            = sbus.push;
    assign rx_pop             = sbus.pop;
    assign tx_holding_write   = st.thr_wr;

endmodule : umls_top

`default_nettype wire

// ==== testbench/uart_modem_and_line_status_tb.sv ====
// Self-checking bench for the modem control, line status and modem status top.
// Assumes the bound checker and the behavioural modem model.
`timescale 1ns/10ps
`default_nettype none
`include "umls_cfg.svh"

module uart_modem_and_line_status_tb;
    localparam logic [2:0] a_hold = `UMLS_ADDR_HOLD;
    localparam logic [2:0] a_mc   = `UMLS_ADDR_MCTL;
    localparam logic [2:0] a_ls   = `UMLS_ADDR_LSTAT;
    localparam logic [2:0] a_ms   = `UMLS_ADDR_MSTAT;
    logic       core_clk, arst_n, rd_strobe, wr_strobe, int_pending, irq, irq_low;
    logic       modem_int, send_clear_low, set_ready_low, call_indicator_low, serial_in;
    logic       carrier_detect_low, terminal_ready_low, send_request_low, serial_out;
    logic       user_pin_a_low, user_pin_b_low, tx_serial, rx_serial, fifo_active;
    logic       rx_head_valid, rx_head_parity_err, rx_head_frame_err, rx_head_break;
    logic       rx_fifo_err_any, rx_char_done, rx_storage_full, rx_push, rx_pop;
    logic       tx_holding_empty, tx_shift_empty, tx_holding_write;
    logic [2:0] addr;
    logic [7:0] wr_data, rd_data, line_format, interrupt_enable, rx_head_data;
    logic [3:0] want, pins;
    int         bad_count, comparisons, pops, pushes, thw, p;

    umls_top umls_top_i
    (
        .*, .clk_en(1'b1), .cs1(1'b1), .cs2(1'b1), .cs_low(1'b0)
    );
    umls_modem_model umls_modem_model_i
    (
        .*
    );

    assign pins = {user_pin_b_low, user_pin_a_low, send_request_low, terminal_ready_low};
    // 40 ns clock
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Pulses are counted, not timed
    always @(posedge core_clk)
    begin
        pops   += rx_pop;
        pushes += rx_push;
        thw    += tx_holding_write;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One register access; read data is settled on return
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        {wr_strobe, rd_strobe, addr, wr_data} = {w, !w, a, d};
        tick(1);
        {wr_strobe, rd_strobe} = 2'b00;
        tick(1);
    endtask : acc
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(rd_data, e);
    endtask : rdc
    task automatic pulse_char;
        rx_char_done = 1'b1;
        tick(1);
        rx_char_done = 1'b0;
        tick(2);
    endtask : pulse_char
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    // Every control nibble onto the pins, mask included
    task automatic t_ctl;
        logic [3:0] v;
        int_pending = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            v = 4'(i);
            acc(1'b1, a_mc, {4'hE, v});
            tick(1);
            chk({serial_out, rx_serial, irq, irq_low, pins}, {1'b1, !serial_in, v[3], !v[3], ~v});
            rdc(a_mc, {4'h0, v});
        end
    endtask : t_ctl
    // Loop-back hides the pins from an active modem
    task automatic t_loop;
        acc(1'b1, a_mc, 8'h15);
        {want, tx_serial} = 5'h00;
        tick(8);
        chk({1'b0, serial_out, rx_serial, irq, pins}, 8'h4F);
        acc(1'b0, a_ms, 8'h00);
        rdc(a_ms, 8'h60);
        tx_serial = 1'b1;
        acc(1'b1, a_mc, 8'h1D);
        tick(1);
        chk({6'h0, rx_serial, irq}, 8'h03);
        acc(1'b1, a_mc, 8'h00);
        want = 4'hF;
        tick(8);
        acc(1'b0, a_ms, 8'h00);
    endtask : t_loop
    // Deltas, the call-indicator edge and the modem interrupt
    task automatic t_msr;
        interrupt_enable = 8'h08;
        want = 4'hE;
        tick(8);
        chk({7'h0, modem_int}, 8'h01);
        rdc(a_ms, 8'h11);
        rdc(a_ms, 8'h10);
        chk({7'h0, modem_int}, 8'h00);
        want = 4'hA;
        tick(8);
        rdc(a_ms, 8'h50);
        want = 4'hE;
        tick(8);
        rdc(a_ms, 8'h14);
        {interrupt_enable, want} = 12'h000;
        tick(8);
        chk({7'h0, modem_int}, 8'h00);
        rdc(a_ms, 8'hFA);
        want = 4'hF;
        tick(8);
        acc(1'b0, a_ms, 8'h00);
    endtask : t_msr
    // Queued flags, queue advance, overrun in both storage modes
    task automatic t_rx;
        rdc(a_ls, 8'h60);
        {fifo_active, rx_fifo_err_any, rx_head_valid} = 3'b111;
        {rx_head_parity_err, rx_head_frame_err, rx_head_break} = 3'b111;
        tick(2);
        rdc(a_ls, 8'hFD);
        rdc(a_ls, 8'hE1);
        {rx_head_parity_err, rx_head_frame_err, rx_head_break} = 3'b010;
        p = pops;
        acc(1'b0, a_hold, 8'h00);
        tick(3);
        chk(8'(pops - p), 8'h01);
        rdc(a_ls, 8'hE9);
        rx_fifo_err_any = 1'b0;
        rdc(a_ls, 8'hE1);
        rdc(a_ls, 8'h61);
        rx_storage_full = 1'b1;
        p = pushes;
        pulse_char;
        chk(8'(pushes - p), 8'h00);
        rdc(a_ls, 8'h63);
        rdc(a_ls, 8'h61);
        {fifo_active, rx_fifo_err_any} = 2'b01;
        pulse_char;
        chk(8'(pushes - p), 8'h01);
        rdc(a_ls, 8'h63);
    endtask : t_rx
    // Transmit empty flags and the holding write strobe
    task automatic t_tx;
        {rx_head_valid, tx_shift_empty} = 2'b00;
        tick(2);
        rdc(a_ls, 8'h20);
        {tx_holding_empty, tx_shift_empty} = 2'b01;
        tick(2);
        rdc(a_ls, 8'h00);
        {tx_holding_empty, tx_shift_empty} = 2'b11;
        p = thw;
        acc(1'b1, a_hold, 8'h5A);
        rdc(a_ls, 8'h00);
        line_format = 8'h80;
        acc(1'b1, a_hold, 8'hA5);
        tick(2);
        chk(8'(thw - p), 8'h01);
    endtask : t_tx

    // Main sequence
    initial
    begin
        {arst_n, rd_strobe, wr_strobe, int_pending, fifo_active, rx_head_valid} = '0;
        {rx_head_parity_err, rx_head_frame_err, rx_head_break, rx_fifo_err_any} = '0;
        {rx_char_done, rx_storage_full, addr, wr_data, line_format} = '0;
        {interrupt_enable, rx_head_data} = 16'h003C;
        {tx_serial, tx_holding_empty, tx_shift_empty, want} = 7'h7F;
        repeat (6) @(posedge core_clk);
        #1 arst_n = 1'b1;
        t_ctl;
        t_loop;
        t_msr;
        t_rx;
        t_tx;
        finish_test;
    end
    // Watchdog, well beyond the roughly 210 cycles the tests take
    initial
    begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        finish_test;
    end
endmodule : uart_modem_and_line_status_tb

`default_nettype wire

// ==== testbench/umls_modem_model.sv ====
// Behavioural modem on the four handshake inputs and the line input.
// Assumes the bench asks for new levels through want.
`timescale 1ns/10ps
`default_nettype none

module umls_modem_model
(
    input  wire logic       core_clk,
    input  wire logic [3:0] want,
    output var  logic       send_clear_low,
    output var  logic       set_ready_low,
    output var  logic       call_indicator_low,
    output var  logic       carrier_detect_low,
    output var  logic       serial_in
);
    // Levels move on the edge after a request
    always @(posedge core_clk)
        {carrier_detect_low, call_indicator_low, set_ready_low, send_clear_low} <= want;
    // Line toggles so a loop-back that leaks the pin cannot pass by luck
    always @(posedge core_clk)
        serial_in <= (serial_in !== 1'b1);
endmodule : umls_modem_model

`default_nettype wire

// ==== testbench/umls_top_properties.sv ====
// Timing checker for the modem and line status top, bound to it.
// Assumes one clock and the register map of umls_cfg.svh.
`timescale 1ns/10ps
`default_nettype none
`include "umls_cfg.svh"

module umls_top_properties
#(
    parameter bit GLOBAL_MASK_OPTION = 1'b1
)
(
    input wire logic       core_clk,
    input wire logic       arst_n,
    input wire logic       clk_en,
    input wire logic [2:0] addr,
    input wire logic       cs1,
    input wire logic       cs2,
    input wire logic       cs_low,
    input wire logic       rd_strobe,
    input wire logic       wr_strobe,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] line_format,
    input wire logic [7:0] interrupt_enable,
    input wire logic       int_pending,
    input wire logic       irq,
    input wire logic       irq_low,
    input wire logic       modem_int,
    input wire logic       send_clear_low,
    input wire logic       set_ready_low,
    input wire logic       call_indicator_low,
    input wire logic       carrier_detect_low,
    input wire logic       terminal_ready_low,
    input wire logic       send_request_low,
    input wire logic       user_pin_a_low,
    input wire logic       user_pin_b_low,
    input wire logic       serial_out,
    input wire logic       fifo_active,
    input wire logic       rx_head_valid,
    input wire logic       rx_char_done,
    input wire logic       rx_storage_full,
    input wire logic       rx_push,
    input wire logic       rx_pop
);
    logic       sel;
    logic       wr_mc;
    logic [3:0] mi;
    logic [3:0] mi_q;
    logic [4:0] mc;
    logic [2:0] quiet;

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    assign sel   = cs1 && cs2 && !cs_low && clk_en;
    assign wr_mc = sel && wr_strobe && addr == `UMLS_ADDR_MCTL;
    assign mi    = {carrier_detect_low, call_indicator_low, set_ready_low, send_clear_low};

    // Control shadow; quiet counts settled cycles
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mc    <= 5'h00;
            mi_q  <= 4'hF;
            quiet <= 3'h0;
        end
        else
        begin
            mi_q <= mi;
            if (wr_mc)
                mc <= wr_data[4:0];
            if (wr_mc || mi != mi_q)
                quiet <= 3'h0;
            else if (quiet != 3'h7)
                quiet <= quiet + 3'h1;
        end
    end

    // Control write steps, split by the loop-back bit
    sequence wr_norm_s;
        wr_mc && !wr_data[4] ##1 !wr_strobe;
    endsequence
    sequence wr_loop_s;
        wr_mc && wr_data[4] ##1 !wr_strobe;
    endsequence
    sequence rd_ms_s;
        sel && rd_strobe && addr == `UMLS_ADDR_MSTAT && quiet == 3'h7;
    endsequence

    ctl_pins_a:
        assert property (wr_norm_s |-> ##1 {user_pin_b_low, user_pin_a_low,
            send_request_low, terminal_ready_low} == ~$past(wr_data[3:0], 2))
        else $error("control pins wrong");
    loop_pins_a:
        assert property (wr_loop_s |-> ##1 {terminal_ready_low, send_request_low,
            user_pin_a_low, user_pin_b_low, serial_out} == 5'h1F)
        else $error("loop-back outputs not high");
    mc_read_a:
        assert property (sel && rd_strobe && addr == `UMLS_ADDR_MCTL
            |=> rd_data == {3'h0, $past(mc)})
        else $error("control readback wrong");
    msr_lvl_a:
        assert property (rd_ms_s ##0 !mc[4] |=> rd_data[7:4] == ~$past(mi))
        else $error("modem levels wrong");
    msr_loop_a:
        assert property (rd_ms_s ##0 mc[4] |=> rd_data[7:4] == {mc[3], mc[2], mc[0], mc[1]})
        else $error("loop-back levels wrong");
    irq_gate_a:
        assert property (int_pending && (mc[3] || !GLOBAL_MASK_OPTION) |=> irq && !irq_low)
        else $error("interrupt pair not active");
    irq_mask_a:
        assert property (!mc[3] && GLOBAL_MASK_OPTION |=> !irq && irq_low)
        else $error("interrupt not masked");
    push_drop_a:
        assert property (rx_char_done && rx_storage_full && fifo_active |=> !rx_push)
        else $error("overrun char stored");
    pop_a:
        assert property (sel && rd_strobe && addr == `UMLS_ADDR_HOLD
            && !line_format[`UMLS_LF_DLAB] && rx_head_valid |=> rx_pop)
        else $error("holding read did not pop");
    modem_int_a:
        assert property (modem_int |-> $past(interrupt_enable[`UMLS_IE_MODEM]))
        else $error("modem interrupt not enabled");
endmodule : umls_top_properties

bind umls_top umls_top_properties #(.GLOBAL_MASK_OPTION(GLOBAL_MASK_OPTION))
    umls_top_properties_i (.*);

`default_nettype wire
